// >>> core/ids_map.svh
// constants of the slave download port: subaddresses, sizes, resets
`ifndef IDS_MAP_SVH
`define IDS_MAP_SVH
`define IDS_ADDR_BASE       6'h1A
`define IDS_GEN_CALL        8'h00
`define IDS_SUB_STATUS      8'h02
`define IDS_SUB_BOOT_CTRL   8'h03
`define IDS_SUB_DL_FIRST    8'h10
`define IDS_SUB_DL_LAST     8'h14
`define IDS_SUB_CTRL_FIRST  8'h40
`define IDS_CK_BYTES        16'h0002
`define IDS_CK_FRAME        16'h0008
`define IDS_WB_MCU          3'h1
`define IDS_WB_COEF         3'h4
`define IDS_WB_CORE         3'h6
`define IDS_CTRL_LAST_BYTE  5'h13
`define IDS_ERR_RST         5'h00
`define IDS_ADDR_RST        16'h0000
`define IDS_SEL_RST         1'h0
`endif

// >>> core/ids_pkg.sv
// types and decode functions of the slave download port
package ids_pkg;
  `include "ids_map.svh"

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_ACK_A = 3'b010,
    ST_WRITE = 3'b011,
    ST_ACK_W = 3'b100,
    ST_READ  = 3'b101,
    ST_ACK_R = 3'b110,
    ST_WAIT  = 3'b111
  } ids_state_e;

  typedef enum logic [2:0] {
    MEM_MCU_PROG  = 3'b000,
    MEM_MCU_XDATA = 3'b001,
    MEM_CORE_COEF = 3'b010,
    MEM_CORE_DATA = 3'b011,
    MEM_CORE_PROG = 3'b100
  } ids_mem_e;

  typedef struct packed {
    logic        we;
    ids_mem_e    mem;
    logic [15:0] addr;
    logic [47:0] data;
  } ids_mem_wr_s;

  typedef struct packed {
    logic         we;
    logic [7:0]   sub;
    logic [159:0] data;
  } ids_ctrl_wr_s;

  // bytes that make one word of a target memory
  function automatic logic [2:0] ids_word_bytes(input ids_mem_e m);
    case (m)
      MEM_MCU_PROG, MEM_MCU_XDATA: ids_word_bytes = `IDS_WB_MCU;
      MEM_CORE_COEF:               ids_word_bytes = `IDS_WB_COEF;
      default:                     ids_word_bytes = `IDS_WB_CORE;
    endcase
  endfunction

  // download register subaddress to memory type
  function automatic ids_mem_e ids_sub_mem(input logic [7:0] sub);
    ids_sub_mem = ids_mem_e'(3'(sub - `IDS_SUB_DL_FIRST));
  endfunction
endpackage

// >>> core/ids_slave.sv
// serial control bus slave with framed memory download
// Functional notes
// - answer at 011010, select bit, r/w bit: four byte addresses
// - select bit loaded after reset from controller, zero by default
// - also answer the broadcast address zero
// - random and sequential subaddress writes both accepted
// - master loads memories, writes control values, reads status
// - controller program memory refuses writes after one load until reset
// - never act as slave while the bus-master function runs
// - block size field counts header, payload and checksum
// - single-word targets carry checksum in a trailing frame's last bytes
// - first word at lowest address, address increments
// - address keeps incrementing across consecutive frames
// - first download byte sets that memory's error bit
// - error bit clears only on complete data and valid checksum
// - header with zero byte count ends the download session
// - status shows boot results until boot control written
// - checksum is low bits of the sum of block bytes
// - checksum sent high byte first
// - acknowledge every written data byte
// - partial control word set discarded at stop or restart
`timescale 1ns/10ps
`include "ids_map.svh"

module ids_slave
  import ids_pkg::*;
(
  input  wire logic         clk_in,
  input  wire logic         srst_in,
  input  wire logic         scl_in,
  input  wire logic         sda_in,
  input  wire logic         master_active_in,
  input  wire logic         address_select_bit_in,
  input  wire logic [7:0]   boot_status_in,
  output logic              sda_out,
  output logic              sda_oe_out,
  output logic              scl_out,
  output logic              scl_oe_out,
  output ids_mem_wr_s       mem_wr_out,
  output ids_ctrl_wr_s      ctrl_wr_out,
  output logic [7:0]        status_out,
  output logic              session_active_out,
  output logic              prog_locked_out
);

  // ****************************************************************
  // pin sampling and bus conditions
  // ****************************************************************
  logic [2:0]  scl_sync_q;
  logic [2:0]  sda_sync_q;
  logic        scl_f_q;
  logic        sda_f_q;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;

  // three stages, a change counts when stages two and three agree
  always_ff @(posedge clk_in) begin : pin_sync
    if (srst_in) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
      scl_f_q    <= 1'h1;
      sda_f_q    <= 1'h1;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], scl_in};
      sda_sync_q <= {sda_sync_q[1:0], sda_in};
      if (scl_sync_q[1] == scl_sync_q[2]) scl_f_q <= scl_sync_q[2];
      if (sda_sync_q[1] == sda_sync_q[2]) sda_f_q <= sda_sync_q[2];
    end
  end

  // edges follow the master's clock only
  assign scl_rise  = (scl_sync_q[1] == scl_sync_q[2]) & scl_sync_q[2] & ~scl_f_q;
  assign scl_fall  = (scl_sync_q[1] == scl_sync_q[2]) & ~scl_sync_q[2] & scl_f_q;
  assign start_det = (sda_sync_q[1] == sda_sync_q[2]) & ~sda_sync_q[2] &
                     sda_f_q & scl_f_q & scl_sync_q[2];
  assign stop_det  = (sda_sync_q[1] == sda_sync_q[2]) & sda_sync_q[2] &
                     ~sda_f_q & scl_f_q & scl_sync_q[2];

  // ****************************************************************
  // address select bit, caught after reset release
  // ****************************************************************
  logic        addr_sel_q;
  logic        strap_done_q;

  always_ff @(posedge clk_in) begin : strap_catch
    if (srst_in) begin
      addr_sel_q   <= `IDS_SEL_RST;
      strap_done_q <= 1'h0;
    end else if (!strap_done_q) begin
      addr_sel_q   <= address_select_bit_in;
      strap_done_q <= 1'h1;
    end
  end

  // ****************************************************************
  // bit engine
  // ****************************************************************
  ids_state_e  st_q;
  logic [3:0]  bitcnt_q;
  logic [7:0]  sr_q;
  logic [7:0]  tx_q;
  logic        rw_q;
  logic        nack_q;
  logic        sda_oe_q;
  logic        addr_hit;
  logic        byte_stb;
  logic        rd_load;
  logic [7:0]  rd_byte;

  // own address or broadcast write
  assign addr_hit = (sr_q[7:1] == {`IDS_ADDR_BASE, addr_sel_q}) |
                    (sr_q == `IDS_GEN_CALL);
  assign byte_stb = scl_fall & (st_q == ST_WRITE) & (bitcnt_q == 4'h8);
  assign rd_load  = scl_fall & rw_q &
                    ((st_q == ST_ACK_A) | (st_q == ST_ACK_R & ~nack_q));

  // slave idles while the bus-master function runs
  always_ff @(posedge clk_in) begin : bit_engine
    if (srst_in || master_active_in) begin
      st_q     <= ST_IDLE;
      bitcnt_q <= 4'h0;
      sr_q     <= 8'h00;
      tx_q     <= 8'h00;
      rw_q     <= 1'h0;
      nack_q   <= 1'h0;
      sda_oe_q <= 1'h0;
    end else if (start_det) begin
      st_q     <= ST_ADDR;
      bitcnt_q <= 4'h0;
      sda_oe_q <= 1'h0;
    end else if (stop_det) begin
      st_q     <= ST_IDLE;
      sda_oe_q <= 1'h0;
    end else if (scl_rise) begin
      if (st_q == ST_ADDR || st_q == ST_WRITE) begin
        sr_q     <= {sr_q[6:0], sda_f_q};
        bitcnt_q <= bitcnt_q + 4'h1;
      end else if (st_q == ST_READ) begin
        bitcnt_q <= bitcnt_q + 4'h1;
      end else if (st_q == ST_ACK_R) begin
        nack_q   <= sda_f_q;
      end
    end else if (scl_fall) begin
      unique case (st_q)
        ST_ADDR: begin
          if (bitcnt_q == 4'h8) begin
            st_q     <= addr_hit ? ST_ACK_A : ST_WAIT;
            sda_oe_q <= addr_hit;
            rw_q     <= sr_q[0];
          end
        end
        ST_WRITE: begin
          if (bitcnt_q == 4'h8) begin
            st_q     <= ST_ACK_W;
            sda_oe_q <= 1'h1;
          end
        end
        ST_ACK_A, ST_ACK_W, ST_ACK_R: begin
          bitcnt_q <= 4'h0;
          if (st_q == ST_ACK_R && nack_q) begin
            st_q     <= ST_WAIT;
            sda_oe_q <= 1'h0;
          end else if (rw_q) begin
            st_q     <= ST_READ;
            tx_q     <= rd_byte;
            sda_oe_q <= ~rd_byte[7];
          end else begin
            st_q     <= ST_WRITE;
            sda_oe_q <= 1'h0;
          end
        end
        ST_READ: begin
          if (bitcnt_q == 4'h8) begin
            st_q     <= ST_ACK_R;
            sda_oe_q <= 1'h0;
          end else begin
            tx_q     <= {tx_q[6:0], 1'h0};
            sda_oe_q <= ~tx_q[6];
          end
        end
        ST_IDLE, ST_WAIT: begin
          sda_oe_q <= 1'h0;
        end
      endcase
    end
  end

  // ****************************************************************
  // subaddress, boot control and status read
  // ****************************************************************
  logic [7:0]  sub_q;
  logic        sub_seen_q;
  logic        boot_seen_q;
  logic [7:0]  rd_idx_q;
  logic [7:0]  status_q;
  logic [4:0]  err_q;
  logic        lock_q;
  logic        session_q;
  logic [7:0]  status_view;

  // boot results until boot control written
  assign status_view = boot_seen_q ? {lock_q, session_q, 1'h0, err_q}
                                   : boot_status_in;
  // status byte first, then zero bytes for later reads and other subaddresses
  assign rd_byte = (sub_q == `IDS_SUB_STATUS && rd_idx_q == 8'h00) ?
                   status_q : 8'h00;

  always_ff @(posedge clk_in) begin : sub_track
    if (srst_in) begin
      sub_q       <= 8'h00;
      sub_seen_q  <= 1'h0;
      boot_seen_q <= 1'h0;
      rd_idx_q    <= 8'h00;
      status_q    <= 8'h00;
    end else begin
      status_q <= status_view;
      if (start_det) begin
        sub_seen_q <= 1'h0;
        rd_idx_q   <= 8'h00;
      end else if (byte_stb && !sub_seen_q) begin
        sub_q      <= sr_q;
        sub_seen_q <= 1'h1;
        if (sr_q == `IDS_SUB_BOOT_CTRL) boot_seen_q <= 1'h1;
      end else if (rd_load && st_q == ST_ACK_R) begin
        rd_idx_q <= rd_idx_q + 8'h01;
      end
    end
  end

  // ****************************************************************
  // framed download
  // ****************************************************************
  logic        dl_sel;
  ids_mem_e    mem;
  logic        refuse;
  logic [15:0] fcnt_q;
  logic [15:0] size_q;
  logic [15:0] sum_q;
  logic [7:0]  ckhi_q;
  logic [47:0] wacc_q;
  logic [2:0]  wcnt_q;
  logic [15:0] addr_q;
  logic        word_done;
  logic        ck_frame;
  logic [15:0] data_end;
  ids_mem_wr_s mem_wr_q;

  assign dl_sel = sub_seen_q & (sub_q >= `IDS_SUB_DL_FIRST) &
                  (sub_q <= `IDS_SUB_DL_LAST);
  assign mem    = ids_sub_mem(sub_q);
  assign refuse = lock_q & (mem == MEM_MCU_PROG);
  assign word_done = (wcnt_q + 3'h1) == ids_word_bytes(mem);
  // single-word targets end with a separate eight-byte checksum frame
  assign ck_frame  = ids_word_bytes(mem) == `IDS_WB_CORE;
  assign data_end  = size_q - (ck_frame ? `IDS_CK_FRAME : `IDS_CK_BYTES);

  always_ff @(posedge clk_in) begin : download
    if (srst_in) begin
      fcnt_q    <= 16'h0000;
      size_q    <= 16'h0000;
      sum_q     <= 16'h0000;
      ckhi_q    <= 8'h00;
      wacc_q    <= 48'h000000000000;
      wcnt_q    <= 3'h0;
      addr_q    <= `IDS_ADDR_RST;
      err_q     <= `IDS_ERR_RST;
      lock_q    <= 1'h0;
      session_q <= 1'h0;
      mem_wr_q  <= '0;
    end else begin
      mem_wr_q.we <= 1'h0;
      if (start_det) begin
        fcnt_q <= 16'h0000;
        wcnt_q <= 3'h0;
        wacc_q <= 48'h000000000000;
      end else if (byte_stb && dl_sel) begin
        fcnt_q <= fcnt_q + 16'h0001;
        if (fcnt_q == 16'h0000) begin
          size_q[15:8] <= sr_q;
          sum_q        <= {8'h00, sr_q};
          session_q    <= 1'h1;
          if (!refuse) err_q[mem] <= 1'h1;
        end else if (fcnt_q == 16'h0001) begin
          size_q[7:0] <= sr_q;
          sum_q       <= sum_q + {8'h00, sr_q};
          if (size_q[15:8] == 8'h00 && sr_q == 8'h00) begin
            session_q <= 1'h0;
            addr_q    <= `IDS_ADDR_RST;
          end
        end else if (size_q != 16'h0000 && fcnt_q < data_end) begin
          sum_q  <= sum_q + {8'h00, sr_q};
          // cleared per word so data stays right-aligned
          wacc_q <= word_done ? 48'h000000000000 : {wacc_q[39:0], sr_q};
          wcnt_q <= word_done ? 3'h0 : wcnt_q + 3'h1;
          if (word_done && !refuse) begin
            mem_wr_q.we   <= 1'h1;
            mem_wr_q.mem  <= mem;
            mem_wr_q.addr <= addr_q;
            mem_wr_q.data <= {wacc_q[39:0], sr_q};
            addr_q        <= addr_q + 16'h0001;
          end
        end else if (size_q != 16'h0000 &&
                     fcnt_q < size_q - `IDS_CK_BYTES) begin
          sum_q <= sum_q + {8'h00, sr_q}; // fill of checksum frame
        end else if (fcnt_q == size_q - `IDS_CK_BYTES) begin
          ckhi_q <= sr_q;
        end else if (fcnt_q == size_q - 16'h0001) begin
          // trailing checksum frame or shared last word
          if ({ckhi_q, sr_q} == sum_q && wcnt_q == 3'h0 && !refuse) begin
            err_q[mem] <= 1'h0;
            if (mem == MEM_MCU_PROG) lock_q <= 1'h1;
          end
        end
      end
    end
  end

  // ****************************************************************
  // control value writes, whole word sets only
  // ****************************************************************
  logic [159:0] cbuf_q;
  logic [4:0]   cbyte_q;
  logic [7:0]   csub_q;
  ids_ctrl_wr_s ctrl_wr_q;

  always_ff @(posedge clk_in) begin : ctrl_path
    if (srst_in) begin
      cbuf_q    <= 160'h0;
      cbyte_q   <= 5'h00;
      csub_q    <= 8'h00;
      ctrl_wr_q <= '0;
    end else begin
      ctrl_wr_q.we <= 1'h0;
      if (start_det || stop_det) begin
        cbyte_q <= 5'h00;
      end else if (byte_stb && !sub_seen_q) begin
        csub_q  <= sr_q;
        cbyte_q <= 5'h00;
      end else if (byte_stb && sub_q >= `IDS_SUB_CTRL_FIRST) begin
        cbuf_q <= {cbuf_q[151:0], sr_q};
        if (cbyte_q == `IDS_CTRL_LAST_BYTE) begin
          ctrl_wr_q.we   <= 1'h1;
          ctrl_wr_q.sub  <= csub_q;
          ctrl_wr_q.data <= {cbuf_q[151:0], sr_q};
          csub_q         <= csub_q + 8'h01;
          cbyte_q        <= 5'h00;
        end else begin
          cbyte_q <= cbyte_q + 5'h01;
        end
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign sda_out            = 1'h0;
  assign sda_oe_out         = sda_oe_q;
  assign scl_out            = 1'h0;
  assign scl_oe_out         = 1'h0;
  assign mem_wr_out         = mem_wr_q;
  assign ctrl_wr_out        = ctrl_wr_q;
  assign status_out         = status_q;
  assign session_active_out = session_q;
  assign prog_locked_out    = lock_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  a_addr_ack: assert property (
    scl_fall && st_q == ST_ADDR && bitcnt_q == 4'h8 && addr_hit &&
    !master_active_in && !start_det && !stop_det
    |=> sda_oe_q && st_q == ST_ACK_A)
    else $error("own address not acknowledged");
  a_foreign_addr: assert property (
    scl_fall && st_q == ST_ADDR && bitcnt_q == 4'h8 && !addr_hit
    |=> !sda_oe_q)
    else $error("foreign address acknowledged");
  a_bcast_hit: assert property (
    scl_fall && st_q == ST_ADDR && bitcnt_q == 4'h8 &&
    sr_q == `IDS_GEN_CALL && !master_active_in |=> sda_oe_q)
    else $error("broadcast address not acknowledged");
  a_master_quiet: assert property (
    master_active_in |=> !sda_oe_q && st_q == ST_IDLE)
    else $error("slave active during master mode");
  a_data_ack: assert property (
    byte_stb && !master_active_in |=> sda_oe_q && st_q == ST_ACK_W)
    else $error("data byte not acknowledged");
  a_lock_refuse: assert property (
    mem_wr_q.we && $past(lock_q, 2) |-> mem_wr_q.mem != MEM_MCU_PROG)
    else $error("write to locked program memory");
  a_err_set: assert property (
    byte_stb && dl_sel && fcnt_q == 16'h0000 && !refuse && !start_det
    |=> err_q[$past(mem)] && session_q)
    else $error("error bit not set at download start");
  a_term_end: assert property (
    byte_stb && dl_sel && fcnt_q == 16'h0001 && !start_det &&
    size_q[15:8] == 8'h00 && sr_q == 8'h00
    |=> !session_q ##1 !session_q || byte_stb)
    else $error("termination did not end session");
  a_addr_step: assert property (
    mem_wr_q.we |-> addr_q == mem_wr_q.addr + 16'h0001)
    else $error("target address did not increment");
  a_status_boot: assert property (
    !$past(srst_in) && !$past(boot_seen_q) |->
    status_q == $past(boot_status_in))
    else $error("status not showing boot result");
  a_ctrl_discard: assert property (
    stop_det && cbyte_q != 5'h00 |=> cbyte_q == 5'h00 && !ctrl_wr_q.we)
    else $error("partial control set not discarded");

endmodule // ids_slave

// >>> verification/ids_bus_master.sv
// serial bus master model on the far side of the download port
`timescale 1ns/10ps

module ids_bus_master (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_oe_out
);
  // ****************************************
  // bus idles released, clock high
  // ****************************************
  initial begin
    scl_out    = 1'b1;
    sda_oe_out = 1'b0;
  end

  // wait n falling clock edges
  task automatic q(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // one bit: data set early in a five-clock low phase, sampled late high;
  // the long low phase covers the slave's lag in releasing an acknowledge
  task automatic bit_io(input logic b, output logic s);
    q(1);
    sda_oe_out = ~b;
    q(4);
    scl_out = 1'b1;
    q(2);
    s = sda_in;
    q(1);
    scl_out = 1'b0;
  endtask

  // data falls while clock high
  task automatic bstart();
    q(2);
    sda_oe_out = 1'b1;
    q(4);
    scl_out = 1'b0;
  endtask

  // data rises while clock high, clock then stands
  task automatic bstop();
    q(2);
    sda_oe_out = 1'b1;
    q(2);
    scl_out = 1'b1;
    q(4);
    sda_oe_out = 1'b0;
    q(4);
  endtask

  // byte out msb first, ack sampled
  task automatic bbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // byte in msb first, then ack or nack
  task automatic bread(output logic [7:0] b, input logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(nack, s);
  endtask
endmodule // ids_bus_master

// >>> verification/tb_top.sv
// self-checking bench of the slave download port
`timescale 1ns/10ps

module tb_top
  import ids_pkg::*;
;
  logic         clk_in  = 1'b0;
  logic         srst_in = 1'b1;
  logic         mact    = 1'b0;
  logic         sel     = 1'b0;
  logic         m_scl, m_oe, u_oe, u_soe, sess, lock, ok;
  wire          scl, sda;
  logic [7:0]   status, v;
  logic [7:0]   tx_q[$];
  ids_mem_wr_s  mem_wr, last_mem;
  ids_ctrl_wr_s ctrl_wr, last_ctl;
  int           n_mem = 0;
  int           n_ctl = 0;
  int           error_cnt = 0;
  int           n_checks = 0;

  // ****************************************
  // clock, wired bus, instances
  // ****************************************
  always #12.5 clk_in = ~clk_in;
  assign sda = ~(m_oe | u_oe);
  assign scl = m_scl & ~u_soe;

  ids_bus_master m (.clk_in(clk_in), .sda_in(sda), .scl_out(m_scl),
                    .sda_oe_out(m_oe));

  ids_slave uut (.clk_in(clk_in), .srst_in(srst_in), .scl_in(scl),
    .sda_in(sda), .master_active_in(mact), .address_select_bit_in(sel),
    .boot_status_in(8'hA5), .sda_out(), .sda_oe_out(u_oe), .scl_out(),
    .scl_oe_out(u_soe), .mem_wr_out(mem_wr), .ctrl_wr_out(ctrl_wr),
    .status_out(status), .session_active_out(sess),
    .prog_locked_out(lock));

  // capture write pulses
  always @(posedge clk_in) begin
    if (mem_wr.we === 1'b1) begin
      n_mem++;
      last_mem = mem_wr;
    end
    if (ctrl_wr.we === 1'b1) begin
      n_ctl++;
      last_ctl = ctrl_wr;
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input string nm, input logic [67:0] s, e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic do_rst(input logic s);
    srst_in = 1'b1;
    sel = s;
    repeat (10) @(negedge clk_in);
    srst_in = 1'b0;
    repeat (6) @(negedge clk_in);
  endtask

  // address then queued bytes, all acks folded
  task automatic xfer(input logic [7:0] a, output logic ok);
    logic ak;
    m.bstart();
    m.bbyte(a, ok);
    foreach (tx_q[i]) if (ok) begin
      m.bbyte(tx_q[i], ak);
      ok &= ak;
    end
    m.bstop();
  endtask

  // download frame: size, payload, checksum
  task automatic dl(input logic [7:0] sub, b0, input int n,
                    input logic bad);
    logic [15:0] sz, ck;
    int          pad;
    pad = (sub >= 8'h13) ? 6 : 0; // trailing checksum frame
    sz = 16'(n + pad + 4);
    tx_q = {sub, sz[15:8], sz[7:0]};
    ck = sz[15:8] + sz[7:0];
    for (int i = 0; i < n; i++) begin
      tx_q.push_back(b0 + 8'(i));
      ck += 16'(b0 + 8'(i));
    end
    repeat (pad) tx_q.push_back(8'h00);
    ck += 16'(bad);
    tx_q.push_back(ck[15:8]);
    tx_q.push_back(ck[7:0]);
    xfer(8'h68, ok);
    chk("dl_ack", ok, 1'b1);
  endtask

  task automatic ctl(input logic [7:0] sub, input int n);
    tx_q = {sub};
    for (int i = 0; i < n; i++) tx_q.push_back(8'h60 + 8'(i));
    xfer(8'h68, ok);
  endtask

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    repeat (60000) @(posedge clk_in);
    error_cnt++;
    end_of_test();
  end

  initial begin
    do_rst(1'b0);
    chk("boot_st", status, 8'hA5);
    tx_q = {};
    xfer(8'h6A, ok);
    chk("foreign", ok, 1'b0);
    tx_q = {8'h03};
    xfer(8'h00, ok);
    chk("gen_call", ok, 1'b1);
    chk("slv_st", status, 8'h00);
    dl(8'h13, 8'h10, 6, 1'b0);
    chk("n_mem", n_mem, 1);
    chk("core_w", last_mem, {1'b1, MEM_CORE_DATA, 16'h0000,
        48'h101112131415});
    chk("st_ok", status, 8'h40);
    dl(8'h12, 8'h20, 4, 1'b1);
    chk("coef_w", last_mem, {1'b1, MEM_CORE_COEF, 16'h0001,
        48'h20212223});
    chk("st_bad", status, 8'h44);
    dl(8'h10, 8'h30, 6, 1'b0);
    chk("n_prog", n_mem, 8);
    chk("prog_w", last_mem, {1'b1, MEM_MCU_PROG, 16'h0007,
        48'h35});
    chk("locked", lock, 1'b1);
    dl(8'h10, 8'h40, 6, 1'b0);
    chk("no_rewr", n_mem, 8);
    tx_q = {8'h02};
    xfer(8'h68, ok);
    m.bstart();
    m.bbyte(8'h69, ok);
    m.bread(v, 1'b1);
    m.bstop();
    chk("rd_st", v, 8'hC4);
    tx_q = {8'h13, 8'h00, 8'h00, 8'h00, 8'h1F};
    repeat (16) tx_q.push_back(8'h00);
    xfer(8'h68, ok);
    chk("term", sess, 1'b0);
    dl(8'h13, 8'h50, 6, 1'b0);
    chk("addr_rst", last_mem.addr, 16'h0000);
    ctl(8'h40, 20);
    chk("ctl_one", n_ctl, 1);
    chk("ctl_dat", last_ctl.data[159:128], 32'h60616263);
    ctl(8'h41, 24);
    chk("ctl_part", n_ctl, 2);
    chk("ctl_sub", last_ctl.sub, 8'h41);
    mact = 1'b1;
    tx_q = {};
    xfer(8'h68, ok);
    chk("mst_act", ok, 1'b0);
    mact = 1'b0;
    do_rst(1'b1);
    chk("unlock", lock, 1'b0);
    xfer(8'h6A, ok);
    chk("sel_one", ok, 1'b1);
    xfer(8'h68, ok);
    chk("sel_zero", ok, 1'b0);
    end_of_test();
  end
endmodule // tb_top
